// [design/pmd_key_guard.sv]
`include "pmd_regs.svh"
`default_nettype none
module pmd_key_guard
(
  input  wire logic       ref_clk,   // core clock
  input  wire logic       rst_b,     // async reset, active low
  input  wire logic       clk_en,    // state freeze when low
  input  wire logic       key_wr,    // write to key register
  input  wire logic [7:0] key_data,  // key write data
  input  wire logic       used,      // protected write consumed the window
  output logic            open       // protected write allowed
);
  import pmd_pkg::*;
  pmd_key_state_t st_r;
  pmd_key_state_t st_nxt;
  logic [2:0]     cnt_r;
  logic [2:0]     cnt_nxt;
  // two-byte key opens a short window
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      PMD_KEY_IDLE:
        if (key_wr && key_data == `PMD_KEY_FIRST)
        begin
          st_nxt  = PMD_KEY_HALF;
          cnt_nxt = `PMD_KEY_WINDOW;
        end
      PMD_KEY_HALF:
        if (key_wr)
        begin
          st_nxt  = (key_data == `PMD_KEY_SECOND) ? PMD_KEY_OPEN : PMD_KEY_IDLE;
          cnt_nxt = `PMD_KEY_WINDOW;
        end
        else if (cnt_r == 3'h0)
          st_nxt = PMD_KEY_IDLE;
        else
          cnt_nxt = cnt_r - 3'h1;
      PMD_KEY_OPEN:
        if (used || cnt_r == 3'h0)
          st_nxt = PMD_KEY_IDLE;
        else
          cnt_nxt = cnt_r - 3'h1;
      default:
        st_nxt = PMD_KEY_IDLE;
    endcase
  end
  assign open = (st_r == PMD_KEY_OPEN);
  // state registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r  <= PMD_KEY_IDLE;
      cnt_r <= 3'h0;
    end
    else if (clk_en)
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// [design/pmd_limit_decode.sv]
`include "pmd_regs.svh"
`default_nettype none
module pmd_limit_decode
(
  input  wire logic [2:0]  code,      // limit code
  input  wire logic [15:0] addr,      // fetch address
  input  wire logic        force_n,   // synchronised external-access level
  output logic             on_chip    // fetch served internally
);
  import pmd_pkg::*;
  logic [15:0] top;
  logic        has_rom;
  // code to top on-chip address
  always_comb
  begin
    has_rom = 1'b1;
    unique case (code)
      3'h1: top = 16'h03ff;
      3'h2: top = 16'h07ff;
      3'h3: top = 16'h0fff;
      3'h4: top = 16'h1fff;
      3'h5: top = `PMD_ROM_TOP;
      default:
      begin
        top     = 16'h0000;
        has_rom = 1'b0;
      end
    endcase
  end
  // compare, pin overrides everything
  assign on_chip = force_n && has_rom && (addr <= top);
endmodule
`default_nettype wire

// [design/pmd_pkg.sv]
`default_nettype none
package pmd_pkg;
  typedef logic [2:0]  pmd_code_t;
  typedef logic [15:0] pmd_addr_t;
  typedef enum logic [1:0]
  {
    PMD_KEY_IDLE = 2'b00,
    PMD_KEY_HALF = 2'b01,
    PMD_KEY_OPEN = 2'b11
  } pmd_key_state_t;
endpackage
`default_nettype wire

// [design/pmd_program_memory_decode.sv]
`include "pmd_regs.svh"
`default_nettype none
module pmd_program_memory_decode
(
  input  wire logic        ref_clk,                  // 40 MHz core clock
  input  wire logic        rst_b,                    // async reset, active low
  input  wire logic        clk_en,                   // freezes all state when low
  input  wire logic [7:0]  reg_addr,                 // register address
  input  wire logic [7:0]  reg_wdata,                // register write data
  input  wire logic        reg_wr,                   // write strobe
  input  wire logic        reg_rd,                   // read strobe
  output logic      [7:0]  reg_rdata,                // read data, cycle after strobe
  input  wire logic        fetch_req,                // fetch request from core
  input  wire logic [15:0] fetch_addr,               // fetch address
  input  wire logic [7:0]  rom_data,                 // on-chip rom data, same cycle
  output logic      [7:0]  fetch_data,               // fetched byte
  output logic             fetch_done,               // fetched byte valid pulse
  output logic             fetch_was_external,       // last fetch went off-chip
  input  wire logic        force_external_fetch_n,   // pin, low forces off-chip
  output logic             program_store_strobe_n,   // external program strobe
  output logic      [7:0]  port_zero_addr_data_o,    // port zero drive value
  output logic             port_zero_addr_data_oe_n, // port zero enable, low drives
  input  wire logic [7:0]  port_zero_addr_data_i,    // port zero pin level
  output logic      [7:0]  port_two_high_addr,       // port two high address
  output logic             ext_bus_busy,             // ports held as memory bus
  input  wire logic [7:0]  gpio_zero_out,            // port zero io value
  input  wire logic        gpio_zero_oe_n,           // port zero io enable
  input  wire logic [7:0]  gpio_two_out              // port two io value
);
  import pmd_pkg::*;

  // pin synchronisers
  logic       ea_s1_r;
  logic       ea_s2_r;
  logic [7:0] p0_s1_r;
  logic [7:0] p0_s2_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ea_s1_r <= 1'b1;
      ea_s2_r <= 1'b1;
      p0_s1_r <= 8'h00;
      p0_s2_r <= 8'h00;
    end
    else if (clk_en)
    begin
      ea_s1_r <= force_external_fetch_n;
      ea_s2_r <= ea_s1_r;
      p0_s1_r <= port_zero_addr_data_i;
      p0_s2_r <= p0_s1_r;
    end
  end

  // register decode
  wire sel_limit = (reg_addr == `PMD_ROM_LIMIT_SELECT_ADDR);
  wire sel_key   = (reg_addr == `PMD_PROT_KEY_ADDR);
  wire sel_stat  = (reg_addr == `PMD_STATUS_ADDR);
  wire key_open;
  wire limit_wr  = reg_wr && sel_limit && key_open;
  wire code_ok   = (reg_wdata[`PMD_CODE_MSB:`PMD_CODE_LSB] <= 3'h5);

  pmd_key_guard u_key
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .key_wr   (reg_wr && sel_key),
    .key_data (reg_wdata),
    .used     (reg_wr && sel_limit),
    .open     (key_open)
  );

  // limit code, reset to 16 kB
  pmd_code_t code_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      code_r <= `PMD_CODE_RESET;
    else if (clk_en && limit_wr && code_ok)
      code_r <= reg_wdata[`PMD_CODE_MSB:`PMD_CODE_LSB];
  end

  // decode uses the live code: a write applies to the next fetch
  wire on_chip;
  pmd_limit_decode u_dec
  (
    .code    (code_r),
    .addr    (fetch_addr),
    .force_n (ea_s2_r),
    .on_chip (on_chip)
  );

  // external fetch sequencer; the data phase runs three cycles so that the
  // byte has passed both pin synchroniser stages before it is taken
  typedef enum logic [2:0]
  {
    PMD_EXT_IDLE = 3'b000,
    PMD_EXT_ADDR = 3'b001,
    PMD_EXT_DATA = 3'b011,
    PMD_EXT_HOLD = 3'b010,
    PMD_EXT_TAKE = 3'b110
  } pmd_ext_state_t;
  pmd_ext_state_t ext_r;
  pmd_ext_state_t ext_nxt;
  pmd_addr_t      addr_r;

  always_comb
  begin
    ext_nxt = ext_r;
    unique case (ext_r)
      PMD_EXT_IDLE: if (fetch_req && !on_chip) ext_nxt = PMD_EXT_ADDR;
      PMD_EXT_ADDR: ext_nxt = PMD_EXT_DATA;
      PMD_EXT_DATA: ext_nxt = PMD_EXT_HOLD;
      PMD_EXT_HOLD: ext_nxt = PMD_EXT_TAKE;
      PMD_EXT_TAKE: ext_nxt = PMD_EXT_IDLE;
      default:      ext_nxt = PMD_EXT_IDLE;
    endcase
  end

  wire start_int = (ext_r == PMD_EXT_IDLE) && fetch_req && on_chip;
  wire in_ext    = (ext_nxt != PMD_EXT_IDLE);

  // bus pins and fetch result, all registered
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_r                    <= PMD_EXT_IDLE;
      addr_r                   <= 16'h0000;
      fetch_data               <= 8'h00;
      fetch_done               <= 1'b0;
      fetch_was_external       <= 1'b0;
      program_store_strobe_n   <= 1'b1;
      port_zero_addr_data_o    <= 8'h00;
      port_zero_addr_data_oe_n <= 1'b1;
      port_two_high_addr       <= 8'h00;
      ext_bus_busy             <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_r        <= ext_nxt;
      fetch_done   <= start_int || (ext_r == PMD_EXT_TAKE);
      ext_bus_busy <= in_ext;
      if (ext_r == PMD_EXT_IDLE && fetch_req)
      begin
        addr_r             <= fetch_addr;
        fetch_was_external <= !on_chip;
      end
      if (start_int)
        fetch_data <= rom_data;
      else if (ext_r == PMD_EXT_TAKE)
        fetch_data <= p0_s2_r;
      // low address on port zero, then release for data
      if (ext_nxt == PMD_EXT_ADDR)
      begin
        port_zero_addr_data_o    <= fetch_addr[7:0];
        port_zero_addr_data_oe_n <= 1'b0;
        port_two_high_addr       <= fetch_addr[15:8];
      end
      else if (in_ext)
      begin
        port_zero_addr_data_oe_n <= 1'b1;
        port_two_high_addr       <= addr_r[15:8];
      end
      else
      begin
        port_zero_addr_data_o    <= gpio_zero_out;
        port_zero_addr_data_oe_n <= gpio_zero_oe_n;
        port_two_high_addr       <= gpio_two_out;
      end
      program_store_strobe_n <= !(in_ext && ext_nxt != PMD_EXT_ADDR);
    end
  end

  // read data, one cycle after strobe; no scratchpad or data sram aliases in here
  wire [7:0] rd_mux = sel_limit ? {5'h00, code_r} :
                      sel_stat  ? {5'h00, key_open, !ea_s2_r, fetch_was_external} :
                      8'h00;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end
endmodule
`default_nettype wire

// [design/pmd_regs.svh]
// Contract
// - on-chip program rom is one contiguous region from 0000 up to 3fff.
// - a fetch above the selected on-chip limit is served from external program memory.
// - a three-bit code selects 0, 1, 2, 4, 8 or 16 kB; codes 110 and 111 are invalid.
// - after reset the code selects the full 16 kB on-chip limit.
// - the code changes only through a timed-access protected write.
// - a new code applies to the very next fetch, even the current one's successor.
// - the limit can be lowered and raised again at run time.
// - the zero code sends the whole 64 kB program space off-chip.
// - external fetches put the low address on port zero and the high byte on port two.
// - while the ports serve as memory bus they are not general-purpose io.
// - force_external_fetch_n low sends every fetch off-chip, whatever the code.
// - each external fetch drives program_store_strobe_n low.
// - the 1 kB data sram never serves program fetches.
// - the 256-byte scratchpad is separate from the data sram, with no overlap.
`ifndef PMD_REGS_SVH
`define PMD_REGS_SVH
`define PMD_ROM_LIMIT_SELECT_ADDR 8'hc2
`define PMD_PROT_KEY_ADDR         8'hc7
`define PMD_STATUS_ADDR           8'hc3
`define PMD_KEY_FIRST             8'haa
`define PMD_KEY_SECOND            8'h55
`define PMD_KEY_WINDOW            3'h3
`define PMD_CODE_RESET            3'h5
`define PMD_CODE_LSB              0
`define PMD_CODE_MSB              2
`define PMD_ROM_TOP               16'h3fff
`endif

// [test/pmd_ext_rom_model.sv]
`default_nettype none
module pmd_ext_rom_model
(
  input  wire logic       ref_clk,   // core clock
  input  wire logic [7:0] addr_o,    // port zero drive
  input  wire logic       oe_n,      // port zero enable
  input  wire logic       strobe_n,  // program strobe
  input  wire logic [7:0] high_addr, // port two
  output logic      [7:0] pin        // port zero level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_r;
  logic [7:0] last_r = 8'h00;
  // latch low address, remember the wire for a floating pattern
  always @(posedge ref_clk)
  begin
    if (!oe_n)
      lo_r <= addr_o;
    last_r <= pin;
  end
  // memory answers only under the strobe, released wire keeps toggling
  assign pin = !oe_n ? addr_o : !strobe_n ? (high_addr ^ lo_r ^ 8'h5a) : ~last_r;
endmodule
`default_nettype wire

// [test/pmd_program_memory_decode_properties.sv]
`default_nettype none
module pmd_program_memory_decode_properties
(
  input wire logic        ref_clk,                  // core clock
  input wire logic        rst_b,                    // async reset
  input wire logic [7:0]  reg_addr,                 // register address
  input wire logic        reg_rd,                   // read strobe
  input wire logic [7:0]  reg_rdata,                // read data
  input wire logic        fetch_req,                // fetch request
  input wire logic [15:0] fetch_addr,               // fetch address
  input wire logic        fetch_done,               // fetch done
  input wire logic        fetch_was_external,       // off-chip flag
  input wire logic        force_external_fetch_n,   // force pin
  input wire logic        program_store_strobe_n,   // program strobe
  input wire logic [7:0]  port_zero_addr_data_o,    // port zero value
  input wire logic        port_zero_addr_data_oe_n, // port zero enable
  input wire logic [7:0]  port_two_high_addr,       // port two value
  input wire logic        ext_bus_busy              // bus held
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a request that the idle sequencer takes
  wire idle_req = fetch_req && !ext_bus_busy;
  // external fetch shape, force pin, rom top and limit readback
  strobe_len_a: assert property ($fell(program_store_strobe_n) |=>
    !program_store_strobe_n[*2] ##1 program_store_strobe_n && fetch_done) else $error("strobe length");
  strobe_bus_a: assert property (!program_store_strobe_n |->
    ext_bus_busy && port_zero_addr_data_oe_n) else $error("strobe outside bus");
  bus_addr_a: assert property ($rose(ext_bus_busy) |-> !port_zero_addr_data_oe_n &&
    port_zero_addr_data_o == $past(fetch_addr[7:0]) &&
    port_two_high_addr == $past(fetch_addr[15:8])) else $error("bad bus address");
  p2_hold_a: assert property (!program_store_strobe_n |->
    $stable(port_two_high_addr)) else $error("high address moved");
  busy_len_a: assert property ($rose(ext_bus_busy) |->
    ext_bus_busy[*4] ##1 !ext_bus_busy) else $error("busy length");
  ext_flag_a: assert property (fetch_done |->
    fetch_was_external == !$past(program_store_strobe_n)) else $error("bad external flag");
  ea_force_a: assert property (!force_external_fetch_n[*3] ##0 idle_req |=>
    ext_bus_busy) else $error("force pin ignored");
  rom_top_a: assert property (idle_req && fetch_addr > 16'h3fff |=>
    ext_bus_busy) else $error("fetch above rom kept inside");
  limit_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hc2 |->
    reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] < 3'h6) else $error("bad limit code");
  // main scenarios
  cover property (idle_req ##1 ext_bus_busy);
  cover property (fetch_done && !fetch_was_external);
  cover property (!force_external_fetch_n && fetch_done);
endmodule
bind pmd_program_memory_decode pmd_program_memory_decode_properties i_props
(
  .ref_clk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .fetch_req, .fetch_addr, .fetch_done,
  .fetch_was_external, .force_external_fetch_n, .program_store_strobe_n,
  .port_zero_addr_data_o, .port_zero_addr_data_oe_n, .port_two_high_addr, .ext_bus_busy
);
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
  import pmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        fetch_req = 1'b0, force_external_fetch_n = 1'b1, gpio_zero_oe_n = 1'b1;
  logic        fetch_done, fetch_was_external, program_store_strobe_n;
  logic        port_zero_addr_data_oe_n, ext_bus_busy;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rom_data = 8'h00;
  logic [7:0]  gpio_zero_out = 8'h69, gpio_two_out = 8'h96;
  logic [7:0]  reg_rdata, fetch_data, port_zero_addr_data_o, port_zero_addr_data_i;
  logic [7:0]  port_two_high_addr;
  pmd_addr_t   fetch_addr = 16'h0000;
  int          failures = 0, checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  pmd_program_memory_decode i_dut
  (
    .ref_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fetch_req, .fetch_addr, .rom_data, .fetch_data, .fetch_done, .fetch_was_external,
    .force_external_fetch_n, .program_store_strobe_n, .port_zero_addr_data_o,
    .port_zero_addr_data_oe_n, .port_zero_addr_data_i, .port_two_high_addr, .ext_bus_busy,
    .gpio_zero_out, .gpio_zero_oe_n, .gpio_two_out
  );
  pmd_ext_rom_model i_mem
  (
    .ref_clk, .addr_o(port_zero_addr_data_o), .oe_n(port_zero_addr_data_oe_n),
    .strobe_n(program_store_strobe_n), .high_addr(port_two_high_addr),
    .pin(port_zero_addr_data_i)
  );
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  // limit changes are issued while no fetch is in flight
  task automatic put_code(input pmd_code_t c);
    wr(8'hc7, 8'haa);
    wr(8'hc7, 8'h55);
    wr(8'hc2, {5'h00, c});
  endtask
  // one fetch; checks source, byte and latency
  task automatic fetch(input pmd_addr_t a, input logic ext);
    int n;
    n = 0;
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    rom_data <= ~a[7:0];
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    @(negedge ref_clk);
    while (fetch_done !== 1'b1 && n < 8)
    begin
      n++;
      @(negedge ref_clk);
    end
    chk({7'h00, fetch_was_external}, {7'h00, ext});
    chk(fetch_data, ext ? (a[15:8] ^ a[7:0] ^ 8'h5a) : ~a[7:0]);
    chk({7'h00, n == (ext ? 4 : 0)}, 8'h01);
  endtask
  task automatic t_reset;
    rd(8'hc2, 8'h05);
    rd(8'h10, 8'h00);
    fetch(16'h3fff, 1'b0);
    fetch(16'h4000, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_locked;
    wr(8'hc2, 8'h01);
    rd(8'hc2, 8'h05);
    wr(8'hc7, 8'haa);
    wr(8'hc7, 8'h55);
    repeat (8) @(posedge ref_clk);
    wr(8'hc2, 8'h01);
    rd(8'hc2, 8'h05);
    // frozen state ignores a full key sequence and limit write
    @(posedge ref_clk);
    clk_en <= 1'b0;
    put_code(3'h1);
    clk_en <= 1'b1;
    rd(8'hc2, 8'h05);
    $display("locked test done");
  endtask
  task automatic t_codes;
    pmd_addr_t top [6] = '{16'h0000, 16'h03ff, 16'h07ff, 16'h0fff, 16'h1fff, 16'h3fff};
    for (int c = 0; c < 8; c++)
    begin
      put_code(3'(c));
      if (c < 6)
        fetch(top[c], c == 0);
      if (c < 6)
        fetch(top[c] + 16'h0001, 1'b1);
      rd(8'hc2, c < 6 ? 8'(c) : 8'h05);
    end
    $display("codes test done");
  endtask
  task automatic t_ea;
    @(posedge ref_clk);
    force_external_fetch_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    fetch(16'h0010, 1'b1);
    @(posedge ref_clk);
    force_external_fetch_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fetch(16'h0010, 1'b0);
    fetch(16'hbeef, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk(port_two_high_addr, 8'h96);
    $display("pin test done");
  endtask
  // verdict
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_locked;
    t_codes;
    t_ea;
    end_sim;
  end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
